/* include/clk_ctrl_pkg.sv */
/*
 Constants for the converter clock-source and delay-loop control block:
 register offsets, field positions, reset values and AXI response codes.
 Assumes a 32-bit AXI4-Lite slave in front, one register per aligned word.
*/
// How it works
// RULE_01: Halve select picks VCO or VCO halved
// RULE_02: Bypass bit picks PLL or direct clock
// RULE_03: Bias power-down bit, resets to zero
// RULE_04: Delay line off and bypassed while set
// RULE_05: Software clears delay line power bits
// RULE_06: Software sets search mode by frequency
// RULE_07: Software programs direction and tuning to one
// RULE_08: Lock status bit, resets to zero
// RULE_09: Lock status refreshed on readback rising edge
// RULE_10: Delay settings loaded on update rising edge
// RULE_11: Enable bit turns loop controller on
// RULE_12: Software holds digital logic until locked
package clk_ctrl_pkg;
  // Printed offsets are not all multiples of four: they are indices
  localparam logic [8:0] IDX_VCO_DIV = 9'h094;
  localparam logic [8:0] IDX_BYPASS = 9'h095;
  localparam logic [8:0] IDX_BIAS = 9'h09a;
  localparam logic [8:0] IDX_DL_PWR = 9'h0c0;
  localparam logic [8:0] IDX_LOOP_CFG = 9'h0c1;
  localparam logic [8:0] IDX_LOCK_STAT = 9'h0c3;
  localparam logic [8:0] IDX_READBACK = 9'h0c7;
  localparam logic [8:0] IDX_FINE_A = 9'h0cc;
  localparam logic [8:0] IDX_FINE_B = 9'h0cd;
  localparam logic [8:0] IDX_UPDATE = 9'h0db;
  localparam logic [8:0] IDX_DIG_HOLD = 9'h100;
  // Byte address is four times the index
  localparam int ADDR_W = 12;
  // Field positions
  localparam int BIT_HALVE = 0;
  localparam int BIT_BYPASS = 0;
  localparam int BIT_BIAS_PD = 7;
  localparam int BIT_DL_PD = 0;
  localparam int BIT_DL_PWR_A = 4;
  localparam int BIT_DL_PWR_B = 5;
  localparam int BIT_LOOP_EN = 0;
  localparam int BIT_DIR_LO = 3;
  localparam int BIT_MODE = 5;
  localparam int BIT_TUNE_LO = 6;
  localparam int BIT_LOCK = 0;
  localparam int BIT_TRIG = 0;
  localparam int BIT_DIG_HOLD = 0;
  localparam int FINE_W = 6;
  // Reset values
  localparam logic [7:0] RST_VCO_DIV = 8'h00;
  localparam logic [7:0] RST_BYPASS = 8'h00;
  localparam logic [7:0] RST_BIAS = 8'h00;
  localparam logic [7:0] RST_DL_PWR = 8'h31;
  localparam logic [7:0] RST_LOOP_CFG = 8'h70;
  localparam logic [7:0] RST_FINE = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_DIG_HOLD = 8'h01;
  // Writable masks; reserved bits read zero, except in the bias register, where all eight bits are writable
  localparam logic [7:0] MSK_ONE = 8'h01;
  localparam logic [7:0] MSK_BIAS = 8'hff;
  localparam logic [7:0] MSK_DL_PWR = 8'h31;
  localparam logic [7:0] MSK_LOOP_CFG = 8'hf9;
  localparam logic [7:0] MSK_FINE = 8'h3f;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/clk_ctrl.sv */
/*
 Clock-source selection and delay-loop control register block.
 AXI4-Lite slave, 32-bit data, one register per word at four times index.
 Assumes dll_lock_raw is synchronous to aclk.
*/
`timescale 1ns/100ps
module clk_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [clk_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address
  input wire logic [clk_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loop lock from the analog delay loop
  input wire logic dll_lock_raw,
  // Clock tree controls
  output logic vco_halve_select,
  output logic pll_bypass_select,
  output logic bias_power_down,
  output logic delay_line_power_down,
  output logic delay_line_power_a,
  output logic delay_line_power_b,
  output logic loop_enable,
  // Settings applied to the loop circuitry, then the digital logic hold
  output logic [1:0] lock_search_direction,
  output logic lock_search_mode,
  output logic [1:0] loop_tuning_setting,
  output logic [5:0] fine_delay_a,
  output logic [5:0] fine_delay_b,
  output logic digital_logic_hold
);
  localparam int FW = clk_ctrl_pkg::FINE_W;

  // State of the block, apart from the edge detector and lock sampler flops
  typedef struct packed {
    logic [7:0] vco_div;
    logic [7:0] bypass;
    logic [7:0] bias;
    logic [7:0] dl_pwr;
    logic [7:0] loop_cfg;
    logic [7:0] readback;
    logic [7:0] fine_a;
    logic [7:0] fine_b;
    logic [7:0] update;
    logic [7:0] dig_hold;
    // Shadow copies loaded into the loop on update
    logic [1:0] app_dir;
    logic app_mode;
    logic [1:0] app_tune;
    logic [FW-1:0] app_fa;
    logic [FW-1:0] app_fb;
    // Bus side
    logic aw_held;
    logic [clk_ctrl_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
  state_t s_q, s_d;

  logic rb_rise; // Readback trigger rising edge
  logic up_rise; // Update trigger rising edge
  logic lock_seen; // Last sampled lock

  // Byte address to register index; misaligned words and words above
  // the nine-bit index space both set the unmapped flag in bit 9
  function automatic logic [9:0] word_index(
    input logic [clk_ctrl_pkg::ADDR_W-1:0] a
  );
    word_index = {(a[1:0] != 2'h0) || a[clk_ctrl_pkg::ADDR_W-1],
      a[clk_ctrl_pkg::ADDR_W-2:2]};
  endfunction

  // True where the index names a register
  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = !i[9] && (
      i[8:0] == clk_ctrl_pkg::IDX_VCO_DIV ||
      i[8:0] == clk_ctrl_pkg::IDX_BYPASS ||
      i[8:0] == clk_ctrl_pkg::IDX_BIAS ||
      i[8:0] == clk_ctrl_pkg::IDX_DL_PWR ||
      i[8:0] == clk_ctrl_pkg::IDX_LOOP_CFG ||
      i[8:0] == clk_ctrl_pkg::IDX_LOCK_STAT ||
      i[8:0] == clk_ctrl_pkg::IDX_READBACK ||
      i[8:0] == clk_ctrl_pkg::IDX_FINE_A ||
      i[8:0] == clk_ctrl_pkg::IDX_FINE_B ||
      i[8:0] == clk_ctrl_pkg::IDX_UPDATE ||
      i[8:0] == clk_ctrl_pkg::IDX_DIG_HOLD);
  endfunction

  // Byte-lane merge into an 8-bit register under a writable mask
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [31:0] d,
    input logic [3:0] st,
    input logic [7:0] m
  );
    merge = st[0] ? ((old & ~m) | (d[7:0] & m)) : old;
  endfunction

  // Edge detectors: trigger bits only act on a 0-to-1 step
  rise_detect u_rb_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(s_q.readback[clk_ctrl_pkg::BIT_TRIG]),
    .rise(rb_rise)
  );

  rise_detect u_up_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(s_q.update[clk_ctrl_pkg::BIT_TRIG]),
    .rise(up_rise)
  );

  // Lock indicator captured only when readback trigger rises
  lock_sampler u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sample(rb_rise), // RULE_09
    .lock_raw(dll_lock_raw),
    .lock_seen(lock_seen)
  );

  // Next state: bus handshakes, register writes, shadow loads
  always_comb begin
    logic [9:0] wi;
    logic [9:0] ri;
    logic do_wr;
    wi = '0;
    ri = '0;
    do_wr = 1'b0;
    s_d = s_q;
    if (ce) begin
      // Capture write address and data in either order
      if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid) begin
        s_d.aw_held = 1'b1;
        s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid) begin
        s_d.w_held = 1'b1;
        s_d.w_data = s_axi_wdata;
        s_d.w_strb = s_axi_wstrb;
      end
      // Both halves held: perform the write and respond
      if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
        do_wr = 1'b1;
        wi = word_index(s_q.aw_addr);
        s_d.aw_held = 1'b0;
        s_d.w_held = 1'b0;
        s_d.bvalid = 1'b1;
        s_d.bresp = is_mapped(wi) ? clk_ctrl_pkg::RESP_OKAY
                                  : clk_ctrl_pkg::RESP_SLVERR;
      end
      if (s_q.bvalid && s_axi_bready) begin
        s_d.bvalid = 1'b0;
      end
      // Register writes; lock status is read-only
      if (do_wr && !wi[9]) begin
        unique case (wi[8:0])
          clk_ctrl_pkg::IDX_VCO_DIV: s_d.vco_div = merge(s_q.vco_div,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_ONE); // RULE_01
          clk_ctrl_pkg::IDX_BYPASS: s_d.bypass = merge(s_q.bypass,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_ONE); // RULE_02
          clk_ctrl_pkg::IDX_BIAS: s_d.bias = merge(s_q.bias,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_BIAS); // RULE_03
          clk_ctrl_pkg::IDX_DL_PWR: s_d.dl_pwr = merge(s_q.dl_pwr,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_DL_PWR); // RULE_04
          clk_ctrl_pkg::IDX_LOOP_CFG: s_d.loop_cfg = merge(s_q.loop_cfg,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_LOOP_CFG); // RULE_11
          clk_ctrl_pkg::IDX_READBACK: s_d.readback = merge(s_q.readback,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_ONE);
          clk_ctrl_pkg::IDX_FINE_A: s_d.fine_a = merge(s_q.fine_a,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_FINE);
          clk_ctrl_pkg::IDX_FINE_B: s_d.fine_b = merge(s_q.fine_b,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_FINE);
          clk_ctrl_pkg::IDX_UPDATE: s_d.update = merge(s_q.update,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_ONE);
          clk_ctrl_pkg::IDX_DIG_HOLD: s_d.dig_hold = merge(s_q.dig_hold,
            s_q.w_data, s_q.w_strb, clk_ctrl_pkg::MSK_ONE);
          default: ; // Unmapped or read-only: no effect
        endcase
      end
      // Shadow load: new loop settings take effect only here
      if (up_rise) begin
        s_d.app_dir = s_q.loop_cfg[clk_ctrl_pkg::BIT_DIR_LO +: 2]; // RULE_10
        s_d.app_mode = s_q.loop_cfg[clk_ctrl_pkg::BIT_MODE]; // RULE_10
        s_d.app_tune = s_q.loop_cfg[clk_ctrl_pkg::BIT_TUNE_LO +: 2];
        s_d.app_fa = s_q.fine_a[FW-1:0]; // RULE_10
        s_d.app_fb = s_q.fine_b[FW-1:0]; // RULE_10
      end
      // Read channel, one read at a time
      if (s_axi_arvalid && !s_q.rvalid) begin
        ri = word_index(s_axi_araddr);
        s_d.rvalid = 1'b1;
        s_d.rresp = is_mapped(ri) ? clk_ctrl_pkg::RESP_OKAY
                                  : clk_ctrl_pkg::RESP_SLVERR;
        s_d.rdata = '0;
        if (!ri[9]) begin
          unique case (ri[8:0])
            clk_ctrl_pkg::IDX_VCO_DIV: s_d.rdata[7:0] = s_q.vco_div;
            clk_ctrl_pkg::IDX_BYPASS: s_d.rdata[7:0] = s_q.bypass;
            clk_ctrl_pkg::IDX_BIAS: s_d.rdata[7:0] = s_q.bias;
            clk_ctrl_pkg::IDX_DL_PWR: s_d.rdata[7:0] = s_q.dl_pwr;
            clk_ctrl_pkg::IDX_LOOP_CFG: s_d.rdata[7:0] = s_q.loop_cfg;
            clk_ctrl_pkg::IDX_LOCK_STAT:
              s_d.rdata[clk_ctrl_pkg::BIT_LOCK] = lock_seen; // RULE_08
            clk_ctrl_pkg::IDX_READBACK: s_d.rdata[7:0] = s_q.readback;
            clk_ctrl_pkg::IDX_FINE_A: s_d.rdata[7:0] = s_q.fine_a;
            clk_ctrl_pkg::IDX_FINE_B: s_d.rdata[7:0] = s_q.fine_b;
            clk_ctrl_pkg::IDX_UPDATE: s_d.rdata[7:0] = s_q.update;
            clk_ctrl_pkg::IDX_DIG_HOLD: s_d.rdata[7:0] = s_q.dig_hold;
            default: ; // Unmapped reads zero
          endcase
        end
      end else if (s_q.rvalid && s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
    end
  end

  // Register all state; reset gives documented values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.vco_div <= clk_ctrl_pkg::RST_VCO_DIV;
      s_q.bypass <= clk_ctrl_pkg::RST_BYPASS;
      s_q.bias <= clk_ctrl_pkg::RST_BIAS; // RULE_03
      s_q.dl_pwr <= clk_ctrl_pkg::RST_DL_PWR; // RULE_04
      s_q.loop_cfg <= clk_ctrl_pkg::RST_LOOP_CFG; // RULE_11
      s_q.readback <= clk_ctrl_pkg::RST_TRIG;
      s_q.fine_a <= clk_ctrl_pkg::RST_FINE;
      s_q.fine_b <= clk_ctrl_pkg::RST_FINE;
      s_q.update <= clk_ctrl_pkg::RST_TRIG;
      s_q.dig_hold <= clk_ctrl_pkg::RST_DIG_HOLD;
      // Applied settings start from the register reset values
      s_q.app_dir <= clk_ctrl_pkg::RST_LOOP_CFG[clk_ctrl_pkg::BIT_DIR_LO +: 2];
      s_q.app_mode <= clk_ctrl_pkg::RST_LOOP_CFG[clk_ctrl_pkg::BIT_MODE];
      s_q.app_tune <=
        clk_ctrl_pkg::RST_LOOP_CFG[clk_ctrl_pkg::BIT_TUNE_LO +: 2];
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from state flops
  assign s_axi_awready = s_q.aw_held;
  assign s_axi_wready = s_q.w_held;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign vco_halve_select = s_q.vco_div[clk_ctrl_pkg::BIT_HALVE]; // RULE_01
  assign pll_bypass_select = s_q.bypass[clk_ctrl_pkg::BIT_BYPASS]; // RULE_02
  assign bias_power_down = s_q.bias[clk_ctrl_pkg::BIT_BIAS_PD]; // RULE_03
  assign delay_line_power_down =
    s_q.dl_pwr[clk_ctrl_pkg::BIT_DL_PD]; // RULE_04
  assign delay_line_power_a = s_q.dl_pwr[clk_ctrl_pkg::BIT_DL_PWR_A];
  assign delay_line_power_b = s_q.dl_pwr[clk_ctrl_pkg::BIT_DL_PWR_B];
  assign loop_enable = s_q.loop_cfg[clk_ctrl_pkg::BIT_LOOP_EN]; // RULE_11
  assign lock_search_direction = s_q.app_dir;
  assign lock_search_mode = s_q.app_mode;
  assign loop_tuning_setting = s_q.app_tune;
  assign fine_delay_a = s_q.app_fa;
  assign fine_delay_b = s_q.app_fb;
  assign digital_logic_hold = s_q.dig_hold[clk_ctrl_pkg::BIT_DIG_HOLD];
endmodule

/* logic/lock_sampler.sv */
/*
 Holds the lock indicator visible to software.
 Assumes lock_raw is synchronous to aclk.
*/
`timescale 1ns/100ps
module lock_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sample,
  input wire logic lock_raw,
  output logic lock_seen
);
  typedef struct packed {
    logic lock;
  } state_t;
  state_t s_q, s_d;

  // Refresh only on request; otherwise the last sample stands
  always_comb begin
    s_d = s_q;
    if (ce && sample) begin
      s_d.lock = lock_raw; // RULE_09
    end
  end

  assign lock_seen = s_q.lock;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0; // RULE_08
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* logic/rise_detect.sv */
/*
 Rising-edge detector on a register bit.
 Assumes the input is a flop in the same clock domain.
*/
`timescale 1ns/100ps
module rise_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic level,
  output logic rise
);
  typedef struct packed {
    logic prev;
  } state_t;
  state_t s_q, s_d;

  // Previous level updated while clock enable is high, held while it is low
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.prev = level;
    end
  end

  // Pulse only on a 0-to-1 step, gated by clock enable
  assign rise = ce & level & ~s_q.prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* tb/clk_ctrl_assertions.sv */
/*
 Concurrent checks on the clock-control register block.
 Assumes it is bound to clk_ctrl and sees only that module's ports.
*/
`timescale 1ns/100ps
module clk_ctrl_assertions (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_wvalid,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic vco_halve_select,
  input logic pll_bypass_select,
  input logic bias_power_down,
  input logic delay_line_power_down,
  input logic delay_line_power_a,
  input logic delay_line_power_b,
  input logic loop_enable,
  input logic [1:0] lock_search_direction,
  input logic lock_search_mode,
  input logic [1:0] loop_tuning_setting,
  input logic [5:0] fine_delay_a,
  input logic [5:0] fine_delay_b,
  input logic digital_logic_hold
);
  // Controls that act as soon as their register is written
  wire [7:0] direct = {vco_halve_select, pll_bypass_select,
    bias_power_down, delay_line_power_down, delay_line_power_a,
    delay_line_power_b, loop_enable, digital_logic_hold};
  // Loop settings that only move through the update shadow
  wire [16:0] shadow = {lock_search_direction, lock_search_mode,
    loop_tuning_setting, fine_delay_a, fine_delay_b};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_values: assert property ($rose(aresetn) |->
    direct == 8'h1d && shadow == {2'h2, 1'h1, 2'h1, 12'h0})
    else $error("controls not at reset values");
  a_direct_on_write: assert property (
    $changed(direct) |-> $rose(s_axi_bvalid))
    else $error("control moved without a write");
  a_shadow_on_update: assert property (
    $changed(shadow) |-> $past(s_axi_bvalid))
    else $error("loop setting moved without a write");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_latency: assert property ($rose(s_axi_rvalid)
    |-> s_axi_arready && $past(s_axi_arvalid))
    else $error("read answer without request");
  a_write_bounded: assert property (s_axi_awvalid && s_axi_wvalid
    && !s_axi_bvalid |-> ##[1:8] s_axi_bvalid)
    else $error("write response late");
  a_slverr_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule

/* tb/clk_ctrl_tb_top.sv */
/*
 Self-checking bench for clk_ctrl: AXI4-Lite master tasks, a monitor that
 compares answers against queued notes, and level checks on the controls.
 Assumes the package is compiled first and the lock input is synchronous.
*/
`timescale 1ns/100ps
module clk_ctrl_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, dll_lock_raw = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, vco_halve_select, pll_bypass_select;
  logic bias_power_down, delay_line_power_down, delay_line_power_a;
  logic delay_line_power_b, loop_enable, lock_search_mode;
  logic digital_logic_hold;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] lock_search_direction, loop_tuning_setting;
  logic [5:0] fine_delay_a, fine_delay_b, ra, rb;
  logic [1:0] bq[$]; // Expected write responses
  logic [33:0] rq[$]; // Expected read response and data
  int fails = 0, samples_checked = 0, cyc = 0;
  // Reset map: index and value after reset
  logic [8:0] idx_t[11] = '{9'h094, 9'h095, 9'h09a, 9'h0c0, 9'h0c1,
    9'h0c3, 9'h0c7, 9'h0cc, 9'h0cd, 9'h0db, 9'h100};
  logic [7:0] rst_t[11] = '{8'h00, 8'h00, 8'h00, 8'h31, 8'h70, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  wire [7:0] direct = {vco_halve_select, pll_bypass_select,
    bias_power_down, delay_line_power_down, delay_line_power_a,
    delay_line_power_b, loop_enable, digital_logic_hold};
  wire [16:0] shadow = {lock_search_direction, lock_search_mode,
    loop_tuning_setting, fine_delay_a, fine_delay_b};
  clk_ctrl i_clk_ctrl (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dll_lock_raw, .vco_halve_select, .pll_bypass_select,
    .bias_power_down, .delay_line_power_down, .delay_line_power_a,
    .delay_line_power_b, .loop_enable, .lock_search_direction,
    .lock_search_mode, .loop_tuning_setting, .fine_delay_a,
    .fine_delay_b, .digital_logic_hold);
  // 125 MHz clock
  always #4 aclk = ~aclk;
  // Counts one comparison, reports a mismatch
  task automatic tally(input bit ok, input string what);
    samples_checked++;
    if (!ok) begin
      fails++;
      $display("BAD %0t %s mismatch", $time, what);
    end
  endtask
  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    tally(g === e, "write response");
  endtask
  task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
    tally(g === e, "read answer");
  endtask
  task automatic cmp_o(input logic [16:0] g, input logic [16:0] e);
    tally(g === e, "control level");
  endtask
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One write; the opening edge keeps a strobe from two drives at once
  task automatic wr(input logic [8:0] i, input logic [7:0] d,
    input logic [1:0] r = clk_ctrl_pkg::RESP_OKAY);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= {1'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // Ready at random; otherwise raised once the response shows, so
    // the slave must also hold a stalled response
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= !s_axi_bready;
    end while (!(s_axi_bvalid && s_axi_bready));
  endtask
  // One read, answer noted for the monitor
  task automatic rd(input logic [8:0] i, input logic [7:0] d,
    input logic [1:0] r = clk_ctrl_pkg::RESP_OKAY);
    @(posedge aclk);
    rq.push_back({r, 24'h0, d});
    s_axi_araddr <= {1'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    // Same stalling scheme as the write response
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= !s_axi_rready;
    end while (!(s_axi_rvalid && s_axi_rready));
  endtask
  // Monitor: each completed handshake takes the oldest note
  always @(posedge aclk) begin
    if (aresetn && s_axi_bvalid && s_axi_bready)
      cmp_b(s_axi_bresp, bq.pop_front());
    if (aresetn && s_axi_rvalid && s_axi_rready)
      cmp_r({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h2f3f160a));
    ra = 6'($urandom) | 6'h01;
    rb = 6'($urandom);
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (idx_t[k]) rd(idx_t[k], rst_t[k]);
    wr(9'h094, 8'h01);
    wr(9'h095, 8'h01);
    wr(9'h09a, 8'h80);
    wr(9'h0c0, 8'hff);
    rd(9'h0c0, 8'h31);
    wr(9'h0c0, 8'h00);
    wr(9'h0c1, 8'h49);
    wr(9'h0cc, {2'h3, ra});
    wr(9'h0cd, {2'h0, rb});
    rd(9'h0cc, {2'h0, ra});
    @(posedge aclk);
    cmp_o({9'h0, direct}, {9'h0, 8'he3});
    cmp_o(shadow, {2'h2, 1'h1, 2'h1, 12'h0});
    wr(9'h0db, 8'h01);
    repeat (2) @(posedge aclk);
    cmp_o(shadow, {2'h1, 1'h0, 2'h1, ra, rb});
    wr(9'h0cc, 8'h00);
    wr(9'h0db, 8'h01); // Still high, so no fresh edge
    repeat (2) @(posedge aclk);
    cmp_o(shadow, {2'h1, 1'h0, 2'h1, ra, rb});
    dll_lock_raw <= 1'h1;
    rd(9'h0c3, 8'h00);
    wr(9'h0c7, 8'h01);
    rd(9'h0c3, 8'h01);
    wr(9'h0c3, 8'h00);
    dll_lock_raw <= 1'h0;
    rd(9'h0c3, 8'h01);
    wr(9'h0c7, 8'h00);
    wr(9'h0c7, 8'h01);
    rd(9'h0c3, 8'h00);
    wr(9'h0c2, 8'h01, clk_ctrl_pkg::RESP_SLVERR);
    rd(9'h0c2, 8'h00, clk_ctrl_pkg::RESP_SLVERR);
    // Frozen clock enable must only stretch the write
    ce <= 1'h0;
    fork
      wr(9'h100, 8'h00);
      begin
        repeat (3) @(posedge aclk);
        ce <= 1'h1;
      end
    join
    rd(9'h100, 8'h00);
    // Second reset in mid-run restores the map
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(9'h0c1, 8'h70);
    rd(9'h09a, 8'h00);
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule
bind clk_ctrl clk_ctrl_assertions i_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .vco_halve_select, .pll_bypass_select,
  .bias_power_down, .delay_line_power_down, .delay_line_power_a,
  .delay_line_power_b, .loop_enable, .lock_search_direction,
  .lock_search_mode, .loop_tuning_setting, .fine_delay_a,
  .fine_delay_b, .digital_logic_hold);
